// ==== verilog/hdrg_pkg.sv ====
// Purpose: shared constants and types for the host doorbell refuse gate
// Assumes: offsets are relative to the decoded memory or I/O window base
// Notes:   one 32-bit doorbell with read/set and clear views
package hdrg_pkg;
    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [11:0] DB_MEM_SET_OFF = 12'h1c0;
    localparam logic [11:0] DB_MEM_CLR_OFF = 12'h1c4;
    localparam logic [11:0] IO_WIN_OFF     = 12'h100;
    localparam logic [11:0] DB_IO_SET_OFF  = 12'h0c0;
    localparam logic [11:0] DB_IO_CLR_OFF  = 12'h0c4;
    localparam logic [31:0] DB_RESET       = 32'h0000_0000;
    // ------------------------------------------------------------------
    // doorbell fields
    // ------------------------------------------------------------------
    localparam int HB_BIT      = 31;
    localparam int LOCK_BIT    = 30;
    localparam int TOG_BIT     = 29;
    localparam int REFUSE_BIT  = 28;
    localparam int HALT_BIT    = 27;
    localparam int UCODE_W     = 27;
    // lock and refuse raise no microcode interrupt
    localparam logic [31:0] UCODE_IRQ_MASK = 32'hafff_ffff;
    // refuse is owned by the adapter side
    localparam logic [31:0] HOST_WR_MASK   = 32'hefff_ffff;
    // ------------------------------------------------------------------
    // interrupt register positions and error type
    // ------------------------------------------------------------------
    localparam int IRQ_HB_REPLY_BIT = 28;
    localparam int IRQ_FATAL_BIT    = 29;
    localparam logic [7:0] HALT_ERR_CODE = 8'h2b;
    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_OK            = 2'b00,
        ST_INFLIGHT_FAIL = 2'b01,
        ST_ABANDONED     = 2'b10,
        ST_SLAVE_FAIL    = 2'b11
    } hdrg_status_t;
    typedef enum logic [0:0] {
        GW_IDLE = 1'b0,
        GW_BUSY = 1'b1
    } hdrg_gw_state_t;
endpackage

// ==== verilog/hdrg_doorbell_gate.sv ====
// Purpose: host doorbell with toggle-refuse handshake and refusing gateway
// Assumes: host accesses are decoded single-cycle strobes on clock_i
// Notes:   read data returns one cycle after the read strobe
`timescale 1ns/1ns
// What this block does
// - host writes doorbell bits to raise a microcode interrupt
// - set view decoded at memory offset 1c0h
// - clear view decoded at memory offset 1c4h
// - both views also decoded in I/O space at 100h plus c0h/c4h
// - heartbeat request makes the adapter set its heartbeat reply
// - heartbeat reply is interrupt register bit 28
// - lock bit 30 is host-only and raises no microcode interrupt
// - adapter clears toggle bit on the same edge that inverts refuse
// - refuse bit 28 adapter-written, host-read, no microcode interrupt
// - refuse low lets adapter transactions go to the host normally
// - refuse high fails in-flight transactions with success-unknown status
// - refuse high fails new and queued transactions as abandoned
// - slave op on a failed transaction ends failed with length zero
// - refuse sets at once without waiting for outstanding transactions
// - refuse never gates interrupts
// - halt bit 27 halts, records error type, sets fatal flag
// - fatal flag is interrupt bit 29, error register gives cause
// - fatal flag holds until the adapter is reset
// - bits 26 to 0 may signal internal microcode interrupts
module hdrg_doorbell_gate #(
    parameter int TAG_W = 4,
    parameter int LEN_W = 16
) (
    input  wire logic             clock_i,
    input  wire logic             sys_rst_i,
    input  wire logic             host_wr_i,
    input  wire logic             host_rd_i,
    input  wire logic             host_io_i,
    input  wire logic [11:0]      host_addr_i,
    input  wire logic [31:0]      host_wdata_i,
    output logic      [31:0]      host_rdata_o,
    output logic                  host_rvalid_o,
    input  wire logic [26:0]      ucode_db_set_i,
    input  wire logic [26:0]      ucode_db_clr_i,
    input  wire logic             hb_reply_clr_i,
    output logic                  ucode_irq_o,
    output logic                  heartbeat_reply_o,
    output logic                  fatal_error_flag_o,
    output logic                  halted_o,
    output logic      [7:0]       error_code_o,
    output logic                  refuse_o,
    input  wire logic             txn_req_valid_i,
    input  wire logic [TAG_W-1:0] txn_req_tag_i,
    output logic                  txn_req_ready_o,
    output logic                  txn_issue_o,
    output logic      [TAG_W-1:0] txn_issue_tag_o,
    input  wire logic             txn_master_done_i,
    output logic                  txn_abort_o,
    output logic                  txn_result_valid_o,
    output logic      [1:0]       txn_result_status_o,
    output logic      [TAG_W-1:0] txn_result_tag_o,
    input  wire logic             slave_op_valid_i,
    input  wire logic [TAG_W-1:0] slave_op_tag_i,
    input  wire logic [LEN_W-1:0] slave_op_len_i,
    input  wire logic             slave_op_release_i,
    output logic                  slave_op_done_o,
    output logic                  slave_op_fail_o,
    output logic      [LEN_W-1:0] slave_op_len_o
);
    // ------------------------------------------------------------------
    // host decode
    // ------------------------------------------------------------------
    logic        hit_set;
    logic        hit_clr;
    logic [31:0] set_v;
    logic [31:0] clr_v;
    logic [31:0] hw_clr;
    logic [31:0] ucode_set;
    logic [31:0] ucode_clr;
    logic [31:0] db_reg;
    logic [31:0] db_next;
    logic [31:0] db_view;
    logic        refuse_reg;
    assign hit_set = host_io_i
        ? host_addr_i == 12'(hdrg_pkg::IO_WIN_OFF
                             + hdrg_pkg::DB_IO_SET_OFF)
        : host_addr_i == hdrg_pkg::DB_MEM_SET_OFF;
    assign hit_clr = host_io_i
        ? host_addr_i == 12'(hdrg_pkg::IO_WIN_OFF
                             + hdrg_pkg::DB_IO_CLR_OFF)
        : host_addr_i == hdrg_pkg::DB_MEM_CLR_OFF;
    // host cannot touch refuse through either view
    assign set_v = (host_wr_i && hit_set) ?
                   (host_wdata_i & hdrg_pkg::HOST_WR_MASK) : 32'h0;
    assign clr_v = (host_wr_i && hit_clr) ?
                   (host_wdata_i & hdrg_pkg::HOST_WR_MASK) : 32'h0;
    assign ucode_set = {5'h00, ucode_db_set_i};
    assign ucode_clr = {5'h00, ucode_db_clr_i};
    // toggle and heartbeat are served in one cycle, then dropped
    always_comb begin
        hw_clr = 32'h0;
        hw_clr[hdrg_pkg::TOG_BIT] = db_reg[hdrg_pkg::TOG_BIT];
        hw_clr[hdrg_pkg::HB_BIT]  = db_reg[hdrg_pkg::HB_BIT];
    end
    // sets win over clears so a fresh host request is never lost
    assign db_next = (db_reg & ~(clr_v | hw_clr | ucode_clr))
                     | set_v | ucode_set;
    // ------------------------------------------------------------------
    // doorbell and refuse state
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            db_reg <= hdrg_pkg::DB_RESET;
        end else begin
            db_reg <= db_next;
        end
    end
    // inverts at once, outstanding transactions are not waited for
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            refuse_reg <= 1'b0;
        end else if (db_reg[hdrg_pkg::TOG_BIT]) begin
            refuse_reg <= ~refuse_reg;
        end
    end
    always_comb begin
        db_view = db_reg;
        db_view[hdrg_pkg::REFUSE_BIT] = refuse_reg;
    end
    assign refuse_o = refuse_reg;
    // lock and refuse masked off; refuse does not gate anything here
    assign ucode_irq_o = |(db_reg & hdrg_pkg::UCODE_IRQ_MASK);
    // both views read back the doorbell; unmapped reads return zero
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            host_rdata_o  <= 32'h0;
            host_rvalid_o <= 1'b0;
        end else begin
            host_rvalid_o <= host_rd_i;
            host_rdata_o  <= (host_rd_i && (hit_set || hit_clr)) ?
                             db_view : 32'h0;
        end
    end

    // ------------------------------------------------------------------
    // heartbeat and halt
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            heartbeat_reply_o <= 1'b0;
        end else if (db_reg[hdrg_pkg::HB_BIT]) begin
            heartbeat_reply_o <= 1'b1;
        end else if (hb_reply_clr_i) begin
            heartbeat_reply_o <= 1'b0;
        end
    end
    // only a reset releases a halt
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            halted_o           <= 1'b0;
            fatal_error_flag_o <= 1'b0;
            error_code_o       <= 8'h00;
        end else if (db_reg[hdrg_pkg::HALT_BIT] && !halted_o) begin
            halted_o           <= 1'b1;
            fatal_error_flag_o <= 1'b1;
            error_code_o       <= hdrg_pkg::HALT_ERR_CODE;
        end
    end

    // ------------------------------------------------------------------
    // gateway toward the host
    // ------------------------------------------------------------------
    hdrg_pkg::hdrg_gw_state_t gw_state_reg;
    logic                     pend_v_reg;
    logic [TAG_W-1:0]         pend_tag_reg;
    logic [TAG_W-1:0]         act_tag_reg;
    logic                     req_take;
    // one queued entry behind the active transaction
    assign txn_req_ready_o = !pend_v_reg;
    assign req_take = txn_req_valid_i && !pend_v_reg;
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            gw_state_reg        <= hdrg_pkg::GW_IDLE;
            pend_v_reg          <= 1'b0;
            pend_tag_reg        <= '0;
            act_tag_reg         <= '0;
            txn_issue_o         <= 1'b0;
            txn_issue_tag_o     <= '0;
            txn_abort_o         <= 1'b0;
            txn_result_valid_o  <= 1'b0;
            txn_result_status_o <= hdrg_pkg::ST_OK;
            txn_result_tag_o    <= '0;
        end else begin
            txn_issue_o        <= 1'b0;
            txn_abort_o        <= 1'b0;
            txn_result_valid_o <= 1'b0;
            case (gw_state_reg)
                hdrg_pkg::GW_IDLE: begin
                    if (pend_v_reg || req_take) begin
                        pend_v_reg <= 1'b0;
                        if (refuse_reg) begin
                            txn_result_valid_o  <= 1'b1;
                            txn_result_status_o <= hdrg_pkg::ST_ABANDONED;
                            txn_result_tag_o    <= pend_v_reg ?
                                pend_tag_reg : txn_req_tag_i;
                        end else begin
                            txn_issue_o     <= 1'b1;
                            txn_issue_tag_o <= pend_v_reg ?
                                pend_tag_reg : txn_req_tag_i;
                            act_tag_reg     <= pend_v_reg ?
                                pend_tag_reg : txn_req_tag_i;
                            gw_state_reg    <= hdrg_pkg::GW_BUSY;
                        end
                    end
                end
                hdrg_pkg::GW_BUSY: begin
                    if (req_take) begin
                        pend_v_reg   <= 1'b1;
                        pend_tag_reg <= txn_req_tag_i;
                    end
                    if (refuse_reg) begin
                        txn_abort_o         <= 1'b1;
                        txn_result_valid_o  <= 1'b1;
                        txn_result_status_o <= hdrg_pkg::ST_INFLIGHT_FAIL;
                        txn_result_tag_o    <= act_tag_reg;
                        gw_state_reg        <= hdrg_pkg::GW_IDLE;
                    end else if (txn_master_done_i) begin
                        txn_result_valid_o  <= 1'b1;
                        txn_result_status_o <= hdrg_pkg::ST_OK;
                        txn_result_tag_o    <= act_tag_reg;
                        gw_state_reg        <= hdrg_pkg::GW_IDLE;
                    end
                end
                default: begin
                    gw_state_reg <= hdrg_pkg::GW_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // failed transaction tracking and slave ops
    // ------------------------------------------------------------------
    logic [(1<<TAG_W)-1:0] failed_map;
    logic                  fail_ev;
    assign fail_ev = txn_result_valid_o
                     && (txn_result_status_o != hdrg_pkg::ST_OK);
    genvar gi;
    generate
        for (gi = 0; gi < (1 << TAG_W); gi++) begin : g_failed
            // a new failure wins over a release in the same cycle
            always_ff @(posedge clock_i) begin
                if (sys_rst_i) begin
                    failed_map[gi] <= 1'b0;
                end else if (fail_ev && txn_result_tag_o == TAG_W'(gi)) begin
                    failed_map[gi] <= 1'b1;
                end else if (slave_op_valid_i && slave_op_release_i
                             && slave_op_tag_i == TAG_W'(gi)) begin
                    failed_map[gi] <= 1'b0;
                end
            end
        end
    endgenerate
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            slave_op_done_o <= 1'b0;
            slave_op_fail_o <= 1'b0;
            slave_op_len_o  <= '0;
        end else begin
            slave_op_done_o <= slave_op_valid_i;
            slave_op_fail_o <= slave_op_valid_i
                               && failed_map[slave_op_tag_i];
            slave_op_len_o  <= (slave_op_valid_i
                               && !failed_map[slave_op_tag_i]) ?
                               slave_op_len_i : '0;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_busy_refused;
        gw_state_reg == hdrg_pkg::GW_BUSY && refuse_reg;
    endsequence
    sequence s_fail_inflight;
        txn_abort_o && txn_result_valid_o
        && txn_result_status_o == hdrg_pkg::ST_INFLIGHT_FAIL;
    endsequence
    sequence s_new_refused;
        gw_state_reg == hdrg_pkg::GW_IDLE && !pend_v_reg
        && txn_req_valid_i && refuse_reg;
    endsequence
    a_set_view_write: assert property (
        host_wr_i && hit_set && host_wdata_i[hdrg_pkg::LOCK_BIT]
        |=> db_reg[hdrg_pkg::LOCK_BIT])
        else $error("set view did not set lock bit");
    a_clear_view_write: assert property (
        host_wr_i && hit_clr && !hit_set
        && host_wdata_i[hdrg_pkg::LOCK_BIT]
        |=> !db_reg[hdrg_pkg::LOCK_BIT])
        else $error("clear view did not clear lock bit");
    a_lock_no_irq: assert property (
        (db_reg & ~(32'h1 << hdrg_pkg::LOCK_BIT)) == 32'h0
        |-> !ucode_irq_o)
        else $error("lock bit raised microcode interrupt");
    a_toggle_done: assert property (
        db_reg[hdrg_pkg::TOG_BIT] && !set_v[hdrg_pkg::TOG_BIT]
        |=> !db_reg[hdrg_pkg::TOG_BIT]
            && refuse_reg != $past(refuse_reg))
        else $error("toggle not completed");
    a_refuse_host_ro: assert property (
        !db_reg[hdrg_pkg::TOG_BIT] |=> $stable(refuse_reg))
        else $error("refuse changed without toggle");
    a_hb_reply: assert property (
        db_reg[hdrg_pkg::HB_BIT] |=> heartbeat_reply_o)
        else $error("heartbeat not answered");
    a_halt_fatal: assert property (
        db_reg[hdrg_pkg::HALT_BIT] |=> halted_o && fatal_error_flag_o
        && error_code_o == hdrg_pkg::HALT_ERR_CODE)
        else $error("halt request not honoured");
    a_fatal_sticky: assert property (
        fatal_error_flag_o |=> fatal_error_flag_o [*8])
        else $error("fatal flag dropped before reset");
    a_inflight_fail: assert property (
        s_busy_refused |=> s_fail_inflight)
        else $error("in-flight transaction not failed");
    a_abandon_new: assert property (
        s_new_refused |=> txn_result_valid_o && !txn_issue_o
        && txn_result_status_o == hdrg_pkg::ST_ABANDONED)
        else $error("new transaction not abandoned");
    a_slave_fail_len: assert property (
        slave_op_valid_i && failed_map[slave_op_tag_i]
        |=> slave_op_fail_o && slave_op_len_o == '0)
        else $error("slave op on failed transaction not failed");
endmodule // hdrg_doorbell_gate

// ==== bench/hdrg_host_model.sv ====
// Purpose: host driver model on the doorbell register bus
// Assumes: one-cycle strobes, read data one cycle after the strobe
// Notes:   released address and data lines show the inverted last value; io holds
`timescale 1ns/1ns
module hdrg_host_model (
    input  wire logic        clock_i,
    output logic             host_wr_o,
    output logic             host_rd_o,
    output logic             host_io_o,
    output logic      [11:0] host_addr_o,
    output logic      [31:0] host_wdata_o,
    input  wire logic [31:0] host_rdata_i,
    input  wire logic        host_rvalid_i
);
    initial begin
        host_wr_o    = 1'b0;
        host_rd_o    = 1'b0;
        host_io_o    = 1'b0;
        host_addr_o  = 12'h000;
        host_wdata_o = 32'h0000_0000;
    end
    // low bits are adapter-private, so the driver never sends ones there
    task automatic wr(input logic io, input logic [11:0] a,
                      input logic [31:0] d);
        @(posedge clock_i);
        host_wr_o    <= 1'b1;
        host_io_o    <= io;
        host_addr_o  <= a;
        host_wdata_o <= {d[31:27], 27'h0};
        @(posedge clock_i);
        host_wr_o    <= 1'b0;
        host_addr_o  <= ~a;
        host_wdata_o <= ~d;
    endtask
    task automatic rd(input logic io, input logic [11:0] a,
                      output logic [31:0] d, output logic v);
        @(posedge clock_i);
        host_rd_o   <= 1'b1;
        host_io_o   <= io;
        host_addr_o <= a;
        @(posedge clock_i);
        host_rd_o   <= 1'b0;
        host_addr_o <= ~a;
        #1;
        d = host_rdata_i;
        v = host_rvalid_i;
    endtask
    task automatic heartbeat();
        wr(1'b0, 12'h1c0, 32'h8000_0000);
    endtask
    task automatic toggle();
        wr(1'b1, 12'h1c0, 32'h2000_0000);
    endtask
endmodule // hdrg_host_model

// ==== bench/host_doorbell_refuse_gate_tb_top.sv ====
// Purpose: self-checking bench for the doorbell refuse gate
// Assumes: gateway queue depth one, halt code from the package
// Notes:   result pulses are logged by a monitor, checked afterwards
`timescale 1ns/1ns
module host_doorbell_refuse_gate_tb_top;
    typedef struct packed {
        logic clr; logic io; logic [31:0] wd; logic [31:0] exp;
    } hdrg_row_t;
    localparam logic [11:0] MS = hdrg_pkg::DB_MEM_SET_OFF;
    localparam logic [11:0] MC = hdrg_pkg::DB_MEM_CLR_OFF;
    localparam logic [11:0] IS = hdrg_pkg::IO_WIN_OFF + hdrg_pkg::DB_IO_SET_OFF;
    localparam logic [11:0] IC = hdrg_pkg::IO_WIN_OFF + hdrg_pkg::DB_IO_CLR_OFF;
    logic clock_i = 1'b0, sys_rst_i = 1'b1;
    logic host_wr_i, host_rd_i, host_io_i, host_rvalid_o;
    logic [11:0] host_addr_i;
    logic [31:0] host_wdata_i, host_rdata_o;
    logic [26:0] ucode_db_set_i = '0, ucode_db_clr_i = '0;
    logic hb_reply_clr_i = 1'b0, txn_req_valid_i = 1'b0;
    logic txn_master_done_i = 1'b0, slave_op_valid_i = 1'b0;
    logic slave_op_release_i = 1'b0;
    logic [3:0] txn_req_tag_i = '0, slave_op_tag_i = '0;
    logic [15:0] slave_op_len_i = '0, slave_op_len_o;
    logic ucode_irq_o, heartbeat_reply_o, fatal_error_flag_o, halted_o;
    logic refuse_o, txn_req_ready_o, txn_issue_o, txn_abort_o;
    logic txn_result_valid_o, slave_op_done_o, slave_op_fail_o;
    logic [7:0] error_code_o;
    logic [1:0] txn_result_status_o;
    logic [3:0] txn_issue_tag_o, txn_result_tag_o;
    logic [5:0] res_q[$];
    logic [3:0] iss_q[$];
    int errors = 0, n_checks = 0, n_abort = 0;
    hdrg_row_t rows[6] = '{
        '{1'b0, 1'b0, 32'h4000_0000, 32'h4000_0000},
        '{1'b1, 1'b1, 32'h0000_0000, 32'h4000_0000},
        '{1'b0, 1'b1, 32'h0000_0000, 32'h4000_0000},
        '{1'b1, 1'b0, 32'h4000_0000, 32'h0000_0000},
        '{1'b0, 1'b0, 32'h1000_0000, 32'h0000_0000},
        '{1'b0, 1'b1, 32'h4000_0000, 32'h4000_0000}};

    initial begin
        forever #10 clock_i = ~clock_i;
    end
    hdrg_host_model host (.clock_i(clock_i), .host_wr_o(host_wr_i),
        .host_rd_o(host_rd_i), .host_io_o(host_io_i),
        .host_addr_o(host_addr_i), .host_wdata_o(host_wdata_i),
        .host_rdata_i(host_rdata_o), .host_rvalid_i(host_rvalid_o));
    hdrg_doorbell_gate #(.TAG_W(4), .LEN_W(16)) dut (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
        .host_io_i(host_io_i), .host_addr_i(host_addr_i),
        .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
        .host_rvalid_o(host_rvalid_o), .ucode_db_set_i(ucode_db_set_i),
        .ucode_db_clr_i(ucode_db_clr_i), .hb_reply_clr_i(hb_reply_clr_i),
        .ucode_irq_o(ucode_irq_o), .heartbeat_reply_o(heartbeat_reply_o),
        .fatal_error_flag_o(fatal_error_flag_o), .halted_o(halted_o),
        .error_code_o(error_code_o), .refuse_o(refuse_o),
        .txn_req_valid_i(txn_req_valid_i), .txn_req_tag_i(txn_req_tag_i),
        .txn_req_ready_o(txn_req_ready_o), .txn_issue_o(txn_issue_o),
        .txn_issue_tag_o(txn_issue_tag_o),
        .txn_master_done_i(txn_master_done_i), .txn_abort_o(txn_abort_o),
        .txn_result_valid_o(txn_result_valid_o),
        .txn_result_status_o(txn_result_status_o),
        .txn_result_tag_o(txn_result_tag_o),
        .slave_op_valid_i(slave_op_valid_i), .slave_op_tag_i(slave_op_tag_i),
        .slave_op_len_i(slave_op_len_i),
        .slave_op_release_i(slave_op_release_i),
        .slave_op_done_o(slave_op_done_o), .slave_op_fail_o(slave_op_fail_o),
        .slave_op_len_o(slave_op_len_o));

    // ------------------------------------------------------------------
    // monitor and helpers
    // ------------------------------------------------------------------
    always @(posedge clock_i) begin
        if (txn_result_valid_o === 1'b1)
            res_q.push_back({txn_result_status_o, txn_result_tag_o});
        if (txn_issue_o === 1'b1) iss_q.push_back(txn_issue_tag_o);
        if (txn_abort_o === 1'b1) n_abort++;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic rdchk(input logic io, input logic [11:0] a,
                         input logic [31:0] e);
        logic [31:0] d;
        logic        v;
        host.rd(io, a, d, v);
        chk(32'(v), 32'h1);
        chk(d, e);
    endtask
    task automatic txn(input logic [3:0] t);
        @(posedge clock_i);
        txn_req_valid_i <= 1'b1;
        txn_req_tag_i   <= t;
        @(posedge clock_i);
        txn_req_valid_i <= 1'b0;
        txn_req_tag_i   <= ~t;
    endtask
    task automatic sop(input logic rel, input logic f, input logic [15:0] l);
        @(posedge clock_i);
        slave_op_valid_i   <= 1'b1;
        slave_op_tag_i     <= 4'h5;
        slave_op_len_i     <= 16'h0040;
        slave_op_release_i <= rel;
        @(posedge clock_i);
        slave_op_valid_i <= 1'b0;
        #1;
        chk(32'(slave_op_done_o), 32'h1);
        chk(32'(slave_op_fail_o), 32'(f));
        chk(32'(slave_op_len_o), 32'(l));
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock_i);
        errors++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        #1;
        chk(32'(refuse_o), 32'h0);
        chk(32'(txn_req_ready_o), 32'h1);
        rdchk(1'b0, MS, hdrg_pkg::DB_RESET);
        $display("test reset done");
        foreach (rows[i]) begin
            host.wr(rows[i].io, rows[i].io ? (rows[i].clr ? IC : IS)
                                           : (rows[i].clr ? MC : MS),
                    rows[i].wd);
            rdchk(~rows[i].io, rows[i].io ? MS : IS, rows[i].exp);
            chk(32'(ucode_irq_o), 32'h0);
        end
        host.wr(1'b0, MC, 32'h4000_0000);
        host.wr(1'b0, 12'h1c8, 32'h4000_0000);
        rdchk(1'b0, 12'h1c8, 32'h0);
        rdchk(1'b0, MS, 32'h0);
        $display("test views done");
        host.heartbeat();
        @(posedge clock_i);
        #1;
        chk(32'(heartbeat_reply_o), 32'h1);
        rdchk(1'b0, MS, 32'h0);
        @(posedge clock_i);
        hb_reply_clr_i <= 1'b1;
        @(posedge clock_i);
        hb_reply_clr_i <= 1'b0;
        @(posedge clock_i);
        #1;
        chk(32'(heartbeat_reply_o), 32'h0);
        $display("test heartbeat done");
        txn(4'h2);
        repeat (2) @(posedge clock_i);
        txn_master_done_i <= 1'b1;
        @(posedge clock_i);
        txn_master_done_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        chk(32'(iss_q[0]), 32'h2);
        chk(32'(res_q[0]), 32'h02);
        txn(4'h3);
        txn(4'h6);
        #1;
        chk(32'(txn_req_ready_o), 32'h0);
        host.toggle();
        repeat (6) @(posedge clock_i);
        chk(32'(refuse_o), 32'h1);
        chk(32'(n_abort), 32'h1);
        chk(32'(res_q[1]), 32'h13);
        chk(32'(res_q[2]), 32'h26);
        rdchk(1'b0, MS, 32'h1000_0000);
        txn(4'h5);
        repeat (3) @(posedge clock_i);
        chk(32'(res_q[3]), 32'h25);
        chk(32'(iss_q.size()), 32'h2);
        $display("test refuse done");
        sop(1'b0, 1'b1, 16'h0000);
        sop(1'b1, 1'b1, 16'h0000);
        sop(1'b0, 1'b0, 16'h0040);
        @(posedge clock_i);
        ucode_db_set_i <= 27'h000_0001;
        @(posedge clock_i);
        ucode_db_set_i <= 27'h0;
        #1;
        chk(32'(ucode_irq_o), 32'h1);
        rdchk(1'b1, IS, 32'h1000_0001);
        @(posedge clock_i);
        ucode_db_clr_i <= 27'h000_0001;
        @(posedge clock_i);
        ucode_db_clr_i <= 27'h0;
        #1;
        chk(32'(ucode_irq_o), 32'h0);
        $display("test slave and internal done");
        host.wr(1'b0, MS, 32'h0800_0000);
        @(posedge clock_i);
        #1;
        chk(32'(halted_o), 32'h1);
        chk(32'(fatal_error_flag_o), 32'h1);
        chk(32'(error_code_o), 32'(hdrg_pkg::HALT_ERR_CODE));
        chk(32'(ucode_irq_o), 32'h1);
        host.wr(1'b0, MC, 32'h0800_0000);
        repeat (5) @(posedge clock_i);
        chk(32'(fatal_error_flag_o), 32'h1);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        #1;
        chk(32'(fatal_error_flag_o), 32'h0);
        $display("test halt done");
        finish_test();
    end
endmodule // host_doorbell_refuse_gate_tb_top
